// *** rtl/bcd_corr_pkg.sv ***
`default_nettype none

package bcd_corr_pkg;

    // ==========================================================
    // Memory map
    // ==========================================================
    localparam logic [19:0] CORR_VALUE_ADDR = 20'hF_00FE;
    localparam logic [7:0]  READ_IDLE_DATA  = 8'h00;

    // ==========================================================
    // Correction constants
    // ==========================================================
    localparam logic [7:0] LOW_FIX    = 8'h06;
    localparam logic [7:0] HIGH_FIX   = 8'h60;
    localparam logic [3:0] NIBBLE_MAX = 4'h9;
    localparam logic [7:0] BYTE_MAX   = 8'h99;

    // ==========================================================
    // Reset values and timing
    // ==========================================================
    localparam logic       OP_SUB_RST   = 1'b0;
    localparam logic       PENDING_RST  = 1'b0;
    localparam logic       CARRY_RST    = 1'b0;
    localparam int         READ_LATENCY = 1;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic carry_flag;
        logic auxiliary_carry_flag;
    } psw_flags_t;

    typedef struct packed {
        logic valid;
        logic is_sub;
        logic carry;
    } alu_event_t;

    typedef struct packed {
        logic valid;
        logic carry;
    } carry_fix_t;

endpackage

`default_nettype wire

// *** rtl/bcd_adjust_calc.sv ***
`timescale 1ns/1ps
`default_nettype none

module bcd_adjust_calc
    import bcd_corr_pkg::*;
(
    // Operands
    input  wire logic [7:0] i_acc,
    input  wire psw_flags_t i_flags,
    input  wire logic       i_is_sub,
    // Result
    output logic      [7:0] o_adj
);

    logic low_fix;
    logic high_fix;

    // ==========================================================
    // Nibble correction decision
    // ==========================================================
    // After a subtract only the flags count; the digit tests are add-only
    always_comb
    begin
        low_fix  = i_flags.auxiliary_carry_flag
                   | (~i_is_sub & (i_acc[3:0] > NIBBLE_MAX));
        high_fix = i_flags.carry_flag
                   | (~i_is_sub & (i_acc > BYTE_MAX));
        o_adj    = (low_fix ? LOW_FIX : 8'h00) | (high_fix ? HIGH_FIX : 8'h00);
    end

endmodule
`default_nettype wire

// *** rtl/bcd_correction_unit.sv ***
`timescale 1ns/1ps
`default_nettype none

module bcd_correction_unit
    import bcd_corr_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    // Datapath state from the core
    input  wire logic [7:0] i_acc,
    input  wire psw_flags_t i_flags,
    input  wire alu_event_t i_alu,
    // Interrupt entry and return
    input  wire logic       i_irq_entry,
    input  wire logic       i_return_from_interrupt_instruction,
    // Internal memory bus
    input  wire logic       i_rd_en,
    input  wire logic       i_wr_en,
    input  wire logic [19:0] i_addr,
    output logic      [7:0] o_rd_data,
    output logic            o_rd_hit,
    // Carry correction towards the flag logic
    output carry_fix_t      o_fix
);

    // ==========================================================
    // Reset release
    // ==========================================================
    logic rst_meta_q;
    logic rst_b_q;

    // Two stages so release is clean against i_clk
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta_q <= 1'b0;
            rst_b_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_b_q    <= rst_meta_q;
        end
    end

    // ==========================================================
    // Correction value
    // ==========================================================
    logic       op_sub_q;
    logic       op_sub_d;
    logic [7:0] adj_now;

    bcd_adjust_calc u_calc (
        .i_acc    (i_acc),
        .i_flags  (i_flags),
        .i_is_sub (op_sub_q),
        .o_adj    (adj_now)
    );

    // ==========================================================
    // Read port
    // ==========================================================
    logic       rd_hit;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic       rd_hit_q;
    logic       rd_hit_d;

    // Writes are not decoded at all, so they cannot disturb anything
    assign rd_hit = i_rd_en & (i_addr == CORR_VALUE_ADDR);

    // Sample the live value in the read cycle
    always_comb
    begin
        rd_hit_d  = rd_hit;
        rd_data_d = rd_hit ? adj_now : READ_IDLE_DATA;
    end

    // Data register left unreset: its content is meaningless until read
    always_ff @(posedge i_clk)
    begin
        rd_data_q <= rd_data_d;
    end

    always_ff @(posedge i_clk or negedge rst_b_q)
    begin
        if (!rst_b_q)
            rd_hit_q <= 1'b0;
        else
            rd_hit_q <= rd_hit_d;
    end

    assign o_rd_data = rd_data_q;
    assign o_rd_hit  = rd_hit_q;

    // ==========================================================
    // Operation tracking and carry merge
    // ==========================================================
    logic pend_q;
    logic pend_d;
    logic bin_cy_q;
    logic bin_cy_d;
    logic sh_sub_q;
    logic sh_sub_d;
    logic sh_pend_q;
    logic sh_pend_d;
    logic sh_cy_q;
    logic sh_cy_d;
    logic fix_valid;

    // Correcting op is the first ALU event after reading the value
    assign fix_valid = i_alu.valid & pend_q;

    // Shadow keeps the tracking across an interrupt; return overrides an ALU event and a read, entry still saves alongside it
    always_comb
    begin
        op_sub_d  = op_sub_q;
        pend_d    = pend_q;
        bin_cy_d  = bin_cy_q;
        sh_sub_d  = sh_sub_q;
        sh_pend_d = sh_pend_q;
        sh_cy_d   = sh_cy_q;
        if (i_alu.valid)
        begin
            pend_d = 1'b0;
            if (!pend_q)
            begin
                op_sub_d = i_alu.is_sub;
                bin_cy_d = i_alu.carry;
            end
        end
        if (rd_hit)
            pend_d = 1'b1;
        if (i_irq_entry)
        begin
            sh_sub_d  = op_sub_q;
            sh_pend_d = pend_q;
            sh_cy_d   = bin_cy_q;
        end
        if (i_return_from_interrupt_instruction)
        begin
            op_sub_d = sh_sub_q;
            pend_d   = sh_pend_q;
            bin_cy_d = sh_cy_q;
        end
    end

    always_ff @(posedge i_clk or negedge rst_b_q)
    begin
        if (!rst_b_q)
        begin
            op_sub_q  <= OP_SUB_RST;
            pend_q    <= PENDING_RST;
            bin_cy_q  <= CARRY_RST;
            sh_sub_q  <= OP_SUB_RST;
            sh_pend_q <= PENDING_RST;
            sh_cy_q   <= CARRY_RST;
        end
        else
        begin
            op_sub_q  <= op_sub_d;
            pend_q    <= pend_d;
            bin_cy_q  <= bin_cy_d;
            sh_sub_q  <= sh_sub_d;
            sh_pend_q <= sh_pend_d;
            sh_cy_q   <= sh_cy_d;
        end
    end

    // Decimal carry or borrow is the earlier one or the new one
    always_comb
    begin
        o_fix.valid = fix_valid;
        o_fix.carry = fix_valid & (bin_cy_q | i_alu.carry);
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_b_q);

    sequence s_read;
        rd_hit;
    endsequence

    sequence s_answer;
        ##1 o_rd_hit;
    endsequence

    property p_read_answers;
        s_read |-> s_answer;
    endproperty
    a_read_answers: assert property (p_read_answers)
        else $error("read hit not answered");

    property p_no_spurious_hit;
        !i_rd_en |=> !o_rd_hit;
    endproperty
    a_no_spurious_hit: assert property (p_no_spurious_hit)
        else $error("hit without read");

    property p_add_value;
        (rd_hit && !op_sub_q) |=> o_rd_data ==
            (((($past(i_flags.auxiliary_carry_flag)) || ($past(i_acc[3:0]) > 4'h9))
              ? 8'h06 : 8'h00) |
             ((($past(i_flags.carry_flag)) || ($past(i_acc) > 8'h99)) ? 8'h60 : 8'h00));
    endproperty
    a_add_value: assert property (p_add_value)
        else $error("add correction wrong");

    property p_sub_value;
        (rd_hit && op_sub_q) |=> o_rd_data ==
            (($past(i_flags.auxiliary_carry_flag) ? 8'h06 : 8'h00) |
             ($past(i_flags.carry_flag) ? 8'h60 : 8'h00));
    endproperty
    a_sub_value: assert property (p_sub_value)
        else $error("sub correction wrong");

    property p_track_op;
        (i_alu.valid && !pend_q && !i_return_from_interrupt_instruction) |=> op_sub_q == $past(i_alu.is_sub);
    endproperty
    a_track_op: assert property (p_track_op)
        else $error("operation kind not tracked");

    property p_carry_merge;
        (fix_valid && bin_cy_q) |-> o_fix.carry;
    endproperty
    a_carry_merge: assert property (p_carry_merge)
        else $error("earlier carry lost");

    property p_fix_once;
        (fix_valid && !rd_hit && !i_return_from_interrupt_instruction) |=> !o_fix.valid;
    endproperty
    a_fix_once: assert property (p_fix_once)
        else $error("carry fix repeated");

    property p_return_from_interrupt_instruction_restore;
        (i_irq_entry && !i_return_from_interrupt_instruction) ##1 (!i_irq_entry)[*1] ##0 i_return_from_interrupt_instruction
            |=> op_sub_q == $past(op_sub_q, 2);
    endproperty
    a_return_from_interrupt_instruction_restore: assert property (p_return_from_interrupt_instruction_restore)
        else $error("operation kind not restored");

    property p_write_inert;
        (i_wr_en && !i_rd_en) |=> !o_rd_hit && o_rd_data == 8'h00;
    endproperty
    a_write_inert: assert property (p_write_inert)
        else $error("write had an effect");

endmodule
`default_nettype wire

// *** dv/cpu_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model
    import bcd_corr_pkg::*;
(
    // Clock
    input  wire logic       i_clk,
    // Core state and bus towards the unit
    output logic [7:0]      o_acc,
    output psw_flags_t      o_flags,
    output alu_event_t      o_alu,
    output logic            o_irq_entry,
    output logic            o_return_from_interrupt_instruction,
    output logic            o_rd_en,
    output logic            o_wr_en,
    output logic [19:0]     o_addr,
    // Answers from the unit
    input  wire logic [7:0] i_rd_data,
    input  wire logic       i_rd_hit,
    input  wire carry_fix_t i_fix
);
    // ==========================================================
    // Core behaviour
    // ==========================================================
    logic [7:0] acc_save;
    psw_flags_t flags_save;

    // Idle bus from time zero
    initial
    begin
        {o_acc, o_flags, o_alu, o_irq_entry, o_return_from_interrupt_instruction, o_rd_en, o_wr_en, o_addr} = '0;
    end

    // Move into the accumulator, flags untouched
    task automatic load(input logic [7:0] a);
        o_acc = a;
        @(posedge i_clk);
        #1;
    endtask

    // Binary add or subtract as a one-cycle event
    task automatic alu_op(input logic sub, input logic [7:0] b, output logic fix_v);
        logic [8:0] r;
        logic [4:0] lo;
        logic       fix_c;
        r  = sub ? {1'b0, o_acc} - {1'b0, b} : {1'b0, o_acc} + {1'b0, b};
        lo = sub ? {1'b0, o_acc[3:0]} - {1'b0, b[3:0]} : {1'b0, o_acc[3:0]} + {1'b0, b[3:0]};
        o_alu   = '{valid: 1'b1, is_sub: sub, carry: r[8]};
        o_acc   = r[7:0];
        o_flags = '{carry_flag: r[8], auxiliary_carry_flag: lo[4]};
        // Fix is combinational, so take it mid-cycle
        @(negedge i_clk);
        fix_v = i_fix.valid;
        fix_c = i_fix.carry;
        @(posedge i_clk);
        #1;
        o_alu = '0;
        o_flags.carry_flag = fix_v ? fix_c : r[8];
    endtask

    // Byte access, held up to the sampling edge
    task automatic rd(input logic [19:0] a, input logic wr, input logic last,
                      output logic [7:0] d, output logic h);
        o_addr  = a;
        o_rd_en = !wr;
        o_wr_en = wr;
        @(posedge i_clk);
        #1;
        // Answer stands for this whole cycle; take it before letting go
        d = i_rd_data;
        h = i_rd_hit;
        if (last)
        begin
            o_rd_en = 1'b0;
            o_wr_en = 1'b0;
            o_addr  = ~a; // Released address must not look valid
            // One idle edge, so the next access never re-drives the strobes at once
            @(posedge i_clk);
            #1;
        end
    endtask

    // Interrupt entry and return; handler keeps the accumulator
    // Each pulse touches only its own strobe, so entry and return may follow directly
    task automatic irq(input logic entry);
        if (entry)
        begin
            acc_save    = o_acc;
            flags_save  = o_flags;
            o_irq_entry = 1'b1;
        end
        else
            o_return_from_interrupt_instruction = 1'b1;
        @(posedge i_clk);
        #1;
        if (entry)
            o_irq_entry = 1'b0;
        else
        begin
            o_return_from_interrupt_instruction  = 1'b0;
            o_acc   = acc_save;
            o_flags = flags_save;
        end
    endtask
endmodule
`default_nettype wire

// *** dv/bcd_correction_unit_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module bcd_correction_unit_tb
    import bcd_corr_pkg::*;
;
    // ==========================================================
    // Harness
    // ==========================================================
    logic        clk;
    logic        rst_b;
    logic [7:0]  acc;
    psw_flags_t  flags;
    alu_event_t  alu;
    logic        irq_entry, return_from_interrupt_instruction, rd_en, wr_en, hit;
    logic [19:0] addr;
    logic [7:0]  rd_data, d;
    carry_fix_t  fix;
    logic        h;
    int          num_errors;
    int          checks_done;

    bcd_correction_unit bcd_correction_unit_i (
        .i_clk(clk), .i_rst_b(rst_b), .i_acc(acc), .i_flags(flags), .i_alu(alu),
        .i_irq_entry(irq_entry), .i_return_from_interrupt_instruction(return_from_interrupt_instruction), .i_rd_en(rd_en), .i_wr_en(wr_en),
        .i_addr(addr), .o_rd_data(rd_data), .o_rd_hit(hit), .o_fix(fix));

    cpu_core_model cpu_core_model_i (
        .i_clk(clk), .o_acc(acc), .o_flags(flags), .o_alu(alu),
        .o_irq_entry(irq_entry), .o_return_from_interrupt_instruction(return_from_interrupt_instruction), .o_rd_en(rd_en), .o_wr_en(wr_en),
        .o_addr(addr), .i_rd_data(rd_data), .i_rd_hit(hit), .i_fix(fix));

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
    end
    always #25 clk = ~clk;

    // ==========================================================
    // Checking and closing
    // ==========================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t ns: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks_done %0d num_errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Binary step; nothing may be pending yet
    task automatic bin(input logic [7:0] a, input logic [7:0] b, input logic sub);
        logic v;
        cpu_core_model_i.load(a);
        cpu_core_model_i.alu_op(sub, b, v);
        check({7'h00, v}, 8'h00, "binary op taken as correcting");
    endtask

    // Read the value, then apply it, compare accumulator and carry
    task automatic fin(input logic sub, input logic [7:0] adj, input logic [7:0] res,
                       input logic cy);
        logic v;
        cpu_core_model_i.rd(CORR_VALUE_ADDR, 1'b0, 1'b1, d, h);
        check({7'h00, h}, 8'h01, "read hit");
        check(d, adj, "correction value");
        cpu_core_model_i.alu_op(sub, d, v);
        check({7'h00, v}, 8'h01, "carry fix valid");
        check(cpu_core_model_i.o_acc, res, "adjusted acc");
        check({7'h00, cpu_core_model_i.o_flags.carry_flag}, {7'h00, cy}, "carry");
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        num_errors  = 0;
        checks_done = 0;
        rst_b       = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        // Refused: a write, then a neighbouring address
        cpu_core_model_i.rd(CORR_VALUE_ADDR, 1'b1, 1'b1, d, h);
        check({7'h00, h}, 8'h00, "write answered");
        check(d, READ_IDLE_DATA, "write data");
        cpu_core_model_i.rd(CORR_VALUE_ADDR + 20'h0_0001, 1'b0, 1'b1, d, h);
        check({7'h00, h}, 8'h00, "other address answered");
        // Additions, carries from both nibbles
        bin(8'h99, 8'h89, 1'b0);
        fin(1'b0, 8'h66, 8'h88, 1'b1);
        bin(8'h85, 8'h15, 1'b0);
        fin(1'b0, 8'h66, 8'h00, 1'b1);
        bin(8'h80, 8'h80, 1'b0);
        fin(1'b0, 8'h60, 8'h60, 1'b1);
        // Subtractions, with and without borrow
        bin(8'h91, 8'h52, 1'b1);
        fin(1'b1, 8'h06, 8'h39, 1'b0);
        bin(8'h10, 8'h01, 1'b1);
        fin(1'b1, 8'h06, 8'h09, 1'b0);
        bin(8'h20, 8'h30, 1'b1);
        fin(1'b1, 8'h60, 8'h90, 1'b1);
        // Back-to-back reads
        bin(8'h12, 8'h34, 1'b0);
        cpu_core_model_i.rd(CORR_VALUE_ADDR, 1'b0, 1'b0, d, h);
        check({7'h00, h}, 8'h01, "first of two reads");
        fin(1'b0, 8'h00, 8'h46, 1'b0);
        // Value follows the live accumulator at read time
        bin(8'h80, 8'h80, 1'b0);
        cpu_core_model_i.load(8'h0A);
        fin(1'b0, 8'h66, 8'h70, 1'b1);
        // Empty handler, then one that leaves a subtract with borrow behind it
        bin(8'h45, 8'h38, 1'b0);
        cpu_core_model_i.irq(1'b1);
        cpu_core_model_i.irq(1'b0);
        cpu_core_model_i.irq(1'b1);
        bin(8'h20, 8'h30, 1'b1);
        fin(1'b1, 8'h60, 8'h90, 1'b1);
        cpu_core_model_i.irq(1'b0);
        // Kind and carry must come back as before entry, not as the handler left them
        fin(1'b0, 8'h06, 8'h83, 1'b0);
        conclude();
    end

    // Hang guard, far beyond the run length of the test
    initial
    begin
        #2_000_000;
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
